// [logic/tw_consts.svh]
// Constants of the two-wire master transmitter: offsets, fields, codes, timing.
// Assumes inclusion by bare name from files compiled after it.
`ifndef TW_CONSTS_SVH
`define TW_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define TW_REG_CTRL       5'h00
`define TW_REG_STATUS     5'h04
`define TW_REG_DATA       5'h08
`define TW_REG_IRQ_STAT   5'h0C
`define TW_REG_IRQ_MASK   5'h10

// ==========================================================
// Control register fields
`define TW_CTRL_FLAG      7
`define TW_CTRL_ACKEN     6
`define TW_CTRL_START     5
`define TW_CTRL_STOP      4
`define TW_CTRL_WCOL      3
`define TW_CTRL_EN        2

// Status register: code in [7:3], prescaler bits in [1:0]
`define TW_STAT_PRES_MSB  1

// ==========================================================
// Status codes, prescaler bits zero
`define TW_SC_START       8'h08
`define TW_SC_RSTART      8'h10
`define TW_SC_AW_ACK      8'h18
`define TW_SC_AW_NACK     8'h20
`define TW_SC_D_ACK       8'h28
`define TW_SC_D_NACK      8'h30
`define TW_SC_AR_ACK      8'h40
`define TW_SC_AR_NACK     8'h48
`define TW_SC_IDLE        8'hF8

// ==========================================================
// Interrupt status bits
`define TW_IRQ_DONE       0
`define TW_IRQ_WCOL       1
`define TW_IRQ_STOP       2

// ==========================================================
// Reset values
`define TW_CTRL_RST       8'h00
`define TW_DATA_RST       8'hFF
`define TW_IRQ_RST        3'h0

// ==========================================================
// Timing: quarter of a serial bit, in ns and in core cycles
`define TW_CLK_NS         20
`define TW_QUARTER_NS     2500
`define TW_QUARTER_CYCLES ((`TW_QUARTER_NS + `TW_CLK_NS - 1) / `TW_CLK_NS)

`endif

// [logic/tw_pkg.sv]
// Types shared by the two-wire master transmitter and its line sequencer.
// Assumes nothing of its surroundings.
package tw_pkg;

  // ==========================================================
  // Line commands of the sequencer
  typedef enum logic [1:0] {
    CMD_START,
    CMD_STOP,
    CMD_WRITE,
    CMD_READ
  } cmd_t;

  // ==========================================================
  // Byte-level states of the controller
  typedef enum logic [2:0] {
    M_IDLE,
    M_WAIT_FREE,
    M_START,
    M_HOLD,
    M_BYTE,
    M_STOP
  } mstate_t;

endpackage

// [logic/line_sequencer.sv]
// Line sequencer: plays one START, STOP or bit on the open-drain lines.
// Assumes synchronised line levels from the caller, one command at a time.
`timescale 1ns/10ps
`include "tw_consts.svh"

module line_sequencer
  import tw_pkg::*;
#(
  parameter int QUARTER = `TW_QUARTER_CYCLES
) (
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  input  wire logic cmd_valid_in,
  input  wire cmd_t cmd_in,
  input  wire logic cmd_bit_in,
  input  wire logic scl_level_in,
  input  wire logic sda_level_in,
  output logic      ready_out,
  output logic      done_out,
  output logic      rx_bit_out,
  output logic      scl_oe_out,
  output logic      sda_oe_out
);

  localparam int CW = $clog2(QUARTER + 1);

  typedef struct packed {
    logic          busy;
    logic [1:0]    phase;
    cmd_t          cmd;
    logic          bitv;
    logic [CW-1:0] cnt;
    logic          scl_oe;
    logic          sda_oe;
    logic          rx;
    logic          done;
  } seq_t;

  seq_t q, d;

  // ==========================================================
  // Drive pattern {scl_oe, sda_oe} for a command phase
  function automatic logic [1:0] levels(cmd_t c, logic [1:0] ph, logic b, logic cur_scl);
    logic [1:0] r;
    r = 2'b00;
    case (c)
      CMD_START: r = (ph == 2'd0) ? {cur_scl, 1'b0} : (ph == 2'd1) ? 2'b00 :
                     (ph == 2'd2) ? 2'b01 : 2'b11;
      CMD_STOP:  r = (ph == 2'd0) ? 2'b11 : (ph == 2'd1) ? 2'b01 : 2'b00;
      CMD_WRITE: r = {(ph == 2'd0) || (ph == 2'd3), ~b};
      default:   r = {(ph == 2'd0) || (ph == 2'd3), 1'b0};
    endcase
    return r;
  endfunction

  // ==========================================================
  // Phase stepping; released clock waits for the line, so a slave may stretch
  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (!q.busy) begin
      if (cmd_valid_in) begin
        d.busy                 = 1'b1;
        d.phase                = 2'd0;
        d.cmd                  = cmd_in;
        d.bitv                 = cmd_bit_in;
        d.cnt                  = '0;
        {d.scl_oe, d.sda_oe}   = levels(cmd_in, 2'd0, cmd_bit_in, q.scl_oe);
      end
    end else if (q.scl_oe || scl_level_in) begin
      if (q.cnt == CW'(QUARTER - 1)) begin
        d.cnt = '0;
        if (q.phase == 2'd2 && q.cmd == CMD_READ) begin
          d.rx = sda_level_in; // Sampled while clock high
        end
        if (q.phase == 2'd3) begin
          d.busy = 1'b0; // Lines keep their last pattern
          d.done = 1'b1;
        end else begin
          d.phase              = q.phase + 2'd1;
          {d.scl_oe, d.sda_oe} = levels(q.cmd, q.phase + 2'd1, q.bitv, q.scl_oe);
        end
      end else begin
        d.cnt = q.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '{busy: 1'b0, phase: 2'd0, cmd: CMD_START, bitv: 1'b0, cnt: '0,
             scl_oe: 1'b0, sda_oe: 1'b0, rx: 1'b1, done: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign ready_out  = !q.busy;
  assign done_out   = q.done;
  assign rx_bit_out = q.rx;
  assign scl_oe_out = q.scl_oe;
  assign sda_oe_out = q.sda_oe;

endmodule

// [logic/two_wire_master_transmitter.sv]
// Two-wire master transmitter with a classic Wishbone register slave.
// Assumes open-drain lines resolved outside; scl/sda inputs are asynchronous.
`timescale 1ns/10ps
`include "tw_consts.svh"

module two_wire_master_transmitter
  import tw_pkg::*;
#(
  parameter int QUARTER = `TW_QUARTER_CYCLES
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [4:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_out,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  output logic             irq_out
);

  typedef struct packed {
    mstate_t     state;
    logic        flag;
    logic        ack_en;
    logic        start;
    logic        stop;
    logic        wcol;
    logic        en;
    logic [1:0]  pres;
    logic [7:0]  code;
    logic [7:0]  data;
    logic [7:0]  shift;
    logic [3:0]  bitcnt;
    logic        pend;
    logic        addr_phase;
    logic        dir_read;
    logic        rep;
    logic        rx_mode;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic        ack;
    logic [31:0] rdata;
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_s3;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_s3;
    logic        bus_busy;
    logic        cmd_valid;
    cmd_t        cmd;
    logic        cmd_bit;
  } top_t;

  top_t q, d;

  logic seq_ready;
  logic seq_done;
  logic seq_rx;
  logic req;
  logic wr;
  logic [2:0] ev;

  // ==========================================================
  // Bit-level line sequencer
  line_sequencer #(
    .QUARTER (QUARTER)
  ) u_seq (
    .core_clk_in  (core_clk_in),
    .rst_n_in     (rst_n_in),
    .cmd_valid_in (q.cmd_valid),
    .cmd_in       (q.cmd),
    .cmd_bit_in   (q.cmd_bit),
    .scl_level_in (q.scl_s2),
    .sda_level_in (q.sda_s2),
    .ready_out    (seq_ready),
    .done_out     (seq_done),
    .rx_bit_out   (seq_rx),
    .scl_oe_out   (scl_oe_out),
    .sda_oe_out   (sda_oe_out)
  );

  // Bus request taken once; ack answers one cycle later
  assign req = wb_cyc_in && wb_stb_in && !q.ack;
  assign wr  = req && wb_we_in && wb_sel_in[0];

  // ==========================================================
  // Register file, controller and synchronisers
  always_comb begin
    d           = q;
    ev          = 3'b000;
    d.cmd_valid = 1'b0;

    // Two-flop synchronisers; only the second stage and later are read
    d.scl_s1 = scl_in;
    d.scl_s2 = q.scl_s1;
    d.scl_s3 = q.scl_s2;
    d.sda_s1 = sda_in;
    d.sda_s2 = q.sda_s1;
    d.sda_s3 = q.sda_s2;

    // Bus activity from START and STOP seen on the lines
    if (q.scl_s2 && q.scl_s3 && q.sda_s3 && !q.sda_s2) begin
      d.bus_busy = 1'b1;
    end else if (q.scl_s2 && q.scl_s3 && !q.sda_s3 && q.sda_s2) begin
      d.bus_busy = 1'b0;
    end

    // Wishbone answer and read data
    d.ack = req;
    if (req) begin
      if (wb_adr_in == `TW_REG_CTRL) begin
        d.rdata = {24'h000000, q.flag, q.ack_en, q.start, q.stop, q.wcol, q.en, 2'b00};
      end else if (wb_adr_in == `TW_REG_STATUS) begin
        d.rdata = {24'h000000, q.code[7:3], 1'b0, q.pres};
      end else if (wb_adr_in == `TW_REG_DATA) begin
        d.rdata = {24'h000000, q.data};
      end else if (wb_adr_in == `TW_REG_IRQ_STAT) begin
        d.rdata = {29'h00000000, q.irq_stat};
      end else if (wb_adr_in == `TW_REG_IRQ_MASK) begin
        d.rdata = {29'h00000000, q.irq_mask};
      end else begin
        d.rdata = 32'h00000000; // Unmapped reads as zero
      end
    end

    // Software writes
    if (wr) begin
      if (wb_adr_in == `TW_REG_CTRL) begin
        d.en     = wb_dat_in[`TW_CTRL_EN];
        d.ack_en = wb_dat_in[`TW_CTRL_ACKEN];
        d.start  = wb_dat_in[`TW_CTRL_START];
        d.stop   = wb_dat_in[`TW_CTRL_STOP];
        if (wb_dat_in[`TW_CTRL_FLAG]) begin
          d.flag = 1'b0; // Writing zero leaves the flag alone
        end
      end else if (wb_adr_in == `TW_REG_STATUS) begin
        d.pres = wb_dat_in[`TW_STAT_PRES_MSB:0];
      end else if (wb_adr_in == `TW_REG_DATA) begin
        if (q.flag) begin
          d.data = wb_dat_in[7:0];
          d.wcol = 1'b0;
        end else begin
          d.wcol = 1'b1; // Write dropped, collision flagged
          ev[`TW_IRQ_WCOL] = 1'b1;
        end
      end else if (wb_adr_in == `TW_REG_IRQ_STAT) begin
        d.irq_stat = q.irq_stat & ~wb_dat_in[2:0];
      end else if (wb_adr_in == `TW_REG_IRQ_MASK) begin
        d.irq_mask = wb_dat_in[2:0];
      end
    end

    // Byte-level controller; decisions use registered flag
    case (q.state)
      M_IDLE: begin
        if (q.en && q.start && !q.flag) begin
          d.state = M_WAIT_FREE;
        end
      end
      M_WAIT_FREE: begin
        if (!q.bus_busy && q.scl_s2 && q.sda_s2) begin // Only on a free bus
          d.rep   = 1'b0;
          d.state = M_START;
        end
      end
      M_START: begin
        if (!q.pend && seq_ready) begin
          d.cmd_valid = 1'b1;
          d.cmd       = CMD_START;
          d.pend      = 1'b1;
        end else if (q.pend && seq_done) begin
          d.pend       = 1'b0;
          d.code       = q.rep ? `TW_SC_RSTART : `TW_SC_START;
          d.flag       = 1'b1; // Set wins over a clear this cycle
          d.addr_phase = 1'b1; // Next byte is a fresh address
          d.rx_mode    = 1'b0;
          d.bus_busy   = 1'b1;
          ev[`TW_IRQ_DONE] = 1'b1;
          d.state      = M_HOLD;
        end
      end
      M_HOLD: begin
        // Sequencer keeps the clock low until the flag clears
        if (!q.flag) begin
          if (q.stop) begin
            d.state = M_STOP;
          end else if (q.start) begin
            d.rep   = 1'b1; // Repeated START keeps the bus
            d.state = M_START;
          end else if (!q.rx_mode) begin
            d.shift    = q.data;
            d.dir_read = q.data[0];
            d.bitcnt   = 4'd0;
            d.state    = M_BYTE;
          end
        end
      end
      M_BYTE: begin
        if (!q.pend && seq_ready) begin
          d.cmd_valid = 1'b1;
          d.cmd       = (q.bitcnt == 4'd8) ? CMD_READ : CMD_WRITE;
          d.cmd_bit   = q.shift[7]; // Most significant bit first
          d.pend      = 1'b1;
        end else if (q.pend && seq_done) begin
          d.pend = 1'b0;
          if (q.bitcnt == 4'd8) begin
            // Low acknowledge bit means ACK
            if (q.addr_phase) begin
              d.rx_mode = q.dir_read;
              if (q.dir_read) begin
                d.code = seq_rx ? `TW_SC_AR_NACK : `TW_SC_AR_ACK;
              end else begin
                d.code = seq_rx ? `TW_SC_AW_NACK : `TW_SC_AW_ACK;
              end
            end else begin
              d.code = seq_rx ? `TW_SC_D_NACK : `TW_SC_D_ACK;
            end
            d.addr_phase = 1'b0;
            d.flag       = 1'b1;
            ev[`TW_IRQ_DONE] = 1'b1;
            d.state      = M_HOLD;
          end else begin
            d.shift  = {q.shift[6:0], 1'b0};
            d.bitcnt = q.bitcnt + 4'd1;
          end
        end
      end
      M_STOP: begin
        if (!q.pend && seq_ready) begin
          d.cmd_valid = 1'b1;
          d.cmd       = CMD_STOP;
          d.pend      = 1'b1;
        end else if (q.pend && seq_done) begin
          d.pend    = 1'b0;
          d.stop    = 1'b0; // Stop request self-clears
          d.rx_mode = 1'b0;
          d.code    = `TW_SC_IDLE;
          ev[`TW_IRQ_STOP] = 1'b1; // No completion flag here
          d.state   = q.start ? M_WAIT_FREE : M_IDLE; // STOP then START
        end
      end
      default: begin
        d.state = M_IDLE;
      end
    endcase

    // Sticky events; a set beats a same-cycle clear
    d.irq_stat = d.irq_stat | ev;
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '{state: M_IDLE, flag: 1'b0, ack_en: 1'b0, start: 1'b0, stop: 1'b0,
             wcol: 1'b0, en: 1'b0, pres: 2'b00, code: `TW_SC_IDLE,
             data: `TW_DATA_RST, shift: 8'h00, bitcnt: 4'd0, pend: 1'b0,
             addr_phase: 1'b0, dir_read: 1'b0, rep: 1'b0, rx_mode: 1'b0,
             irq_stat: `TW_IRQ_RST, irq_mask: `TW_IRQ_RST, ack: 1'b0,
             rdata: 32'h00000000, scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1,
             sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1, bus_busy: 1'b0,
             cmd_valid: 1'b0, cmd: CMD_START, cmd_bit: 1'b0};
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs; open-drain lines only ever pull low
  assign wb_dat_out = q.rdata;
  assign wb_ack_out = q.ack;
  assign scl_out    = 1'b0;
  assign sda_out    = 1'b0;
  assign irq_out    = |(q.irq_stat & q.irq_mask);

endmodule

// [test/tw_master_properties.sv]
// Checker of the two-wire master transmitter, watching its ports only.
// Assumes a classic Wishbone master and pulled-up serial lines.
`timescale 1ns/10ps
`include "tw_consts.svh"

module tw_master_properties #(
  parameter int QUARTER = `TW_QUARTER_CYCLES
) (
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [4:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe_out,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_out,
  input wire logic        irq_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  // ==========================================================
  // Released time of the clock line, saturating so idle reads long
  logic [7:0] rel_q;
  logic [7:0] rel_d;
  always_comb begin
    rel_d = scl_oe_out ? 8'h00 : rel_q + {7'h00, rel_q != 8'hFF};
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rel_q <= 8'hFF;
    end else begin
      rel_q <= rel_d;
    end
  end

  // ==========================================================
  // Steps of bus cycles and line conditions
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_start;
    $rose(sda_oe_out) && !scl_oe_out;
  endsequence
  sequence s_stop;
    $fell(sda_oe_out) && !scl_oe_out;
  endsequence
  wire rd_ack = wb_ack_out && !wb_we_in;

  // ==========================================================
  // Assertions
  AST_ACK_NEXT: assert property (s_req |=> wb_ack_out)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_out |-> $past(wb_cyc_in) && $past(wb_stb_in))
    else $error("ack without request");
  AST_UNMAPPED: assert property (rd_ack && wb_adr_in > 5'h10 |-> wb_dat_out == 32'h0)
    else $error("unmapped read not zero");
  AST_OPEN_DRAIN: assert property (!scl_out && !sda_out)
    else $error("line driven high");
  AST_STRETCH: assert property (rd_ack && wb_adr_in == `TW_REG_CTRL
      && wb_dat_out[`TW_CTRL_FLAG] |-> scl_oe_out)
    else $error("clock released while flag set");
  AST_START_FREE: assert property (s_start |-> $past(sda_in) && scl_in)
    else $error("start on busy lines");
  AST_START_SEQ: assert property (s_start |-> sda_oe_out throughout
      (##[1:QUARTER] scl_oe_out))
    else $error("clock not pulled one quarter after start");
  AST_STOP_QUIET: assert property (s_stop |=> !scl_oe_out [*3])
    else $error("clock pulled right after stop");
  AST_SCL_HIGH: assert property ($rose(scl_oe_out) |-> rel_q >= 2 * QUARTER)
    else $error("clock high phase too short");
endmodule

// [test/tw_slave_model.sv]
// Slave receiver on the two-wire bus, sampling the lines on the core clock.
// Assumes pulled-up lines resolved by the bench; it only ever pulls data low.
`timescale 1ns/10ps

module tw_slave_model (
  input  wire logic clk_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic nack_addr_in,
  output logic       sda_oe_out,
  output logic [7:0] rx_byte_out,
  output logic [7:0] bytes_out,
  output logic [7:0] stops_out
);
  logic       scl_q;
  logic       sda_q;
  logic       frame;
  logic       first;
  logic [3:0] cnt;
  logic [7:0] sh;
  initial begin
    {scl_q, sda_q, frame, first, cnt, sh} = 16'h0000;
    {sda_oe_out, rx_byte_out, bytes_out, stops_out} = 25'h0;
  end

  // ==========================================================
  // Edges found by sampling, so simultaneous line changes never race
  always @(posedge clk_in) begin
    if (scl_q && scl_in && sda_q && !sda_in) begin
      {frame, first, cnt} = {1'b1, 1'b1, 4'h0};
    end else if (scl_q && scl_in && !sda_q && sda_in) begin
      frame = 1'b0;
      stops_out <= stops_out + 8'h01;
    end else if (frame && !scl_q && scl_in) begin
      if (cnt < 4'h8) sh = {sh[6:0], sda_in};  // Eight bits, first bit on top
      cnt = cnt + 4'h1;
    end else if (frame && scl_q && !scl_in && cnt == 4'h8) begin
      sda_oe_out <= !(first && nack_addr_in);  // Ack low, nack left high
    end else if (frame && scl_q && !scl_in && cnt == 4'h9) begin
      {sda_oe_out, rx_byte_out} <= {1'b0, sh};
      bytes_out <= bytes_out + 8'h01;
      {cnt, first} = {4'h0, 1'b0};
    end
    {scl_q, sda_q} = {scl_in, sda_in};
  end
endmodule

// [test/tb_top.sv]
// Bench of the two-wire master transmitter facing a slave receiver model.
// Assumes the design compiled first; with QUARTER of 2 a bit keeps the sequencer busy ten core cycles and bits start thirteen apart.
`timescale 1ns/10ps
`include "tw_consts.svh"

module tb_top;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        we       = 1'b0;
  logic        nack     = 1'b0;
  logic [4:0]  adr      = 5'h00;
  logic [31:0] wdat     = 32'h0;
  logic [31:0] rdat;
  logic        ack, scl_oe, sda_oe, s_oe, irq, scl_o, sda_o;
  logic [7:0]  rx, nbytes, nstops, q;
  wire         scl = ~scl_oe;  // Pull-ups: a released line reads high
  wire         sda = ~(sda_oe | s_oe);
  int          err_count    = 0;
  int          total_checks = 0;
  int          seed         = 71;
  logic [4:0]  ra [6] = '{`TW_REG_CTRL, `TW_REG_STATUS, `TW_REG_DATA,
                          `TW_REG_IRQ_STAT, `TW_REG_IRQ_MASK, 5'h14};
  logic [7:0]  rv [6] = '{`TW_CTRL_RST, `TW_SC_IDLE, `TW_DATA_RST, 8'h00, 8'h00, 8'h00};
  always #10 core_clk = ~core_clk;

  two_wire_master_transmitter #(.QUARTER(2)) u_dut (
    .core_clk_in(core_clk), .rst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .scl_in(scl), .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .irq_out(irq));
  tw_slave_model u_slave (.clk_in(core_clk), .scl_in(scl), .sda_in(sda),
    .nack_addr_in(nack), .sda_oe_out(s_oe), .rx_byte_out(rx), .bytes_out(nbytes),
    .stops_out(nstops));

  // ==========================================================
  // Verdict, comparison and bus tasks
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // One classic cycle; the answer is taken only at the edge that shows ack
  task automatic wb(input logic w, input logic [4:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, ad, 24'h0, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk_byte("wb_ack", 8'h01, 8'h00);
    q = rdat[7:0];
    {cyc, stb} <= 2'b00;
  endtask
  // Polls the flag; bounded so a lost flag cannot hang the run
  task automatic wait_flag;
    int n;
    n = 0;
    q = 8'h00;
    while (q[`TW_CTRL_FLAG] !== 1'b1 && n < 200) begin
      wb(1'b0, `TW_REG_CTRL, 8'h00);
      n++;
    end
    chk_byte("flag", 8'h01, {7'h00, q[`TW_CTRL_FLAG]});
  endtask
  task automatic step(input logic [7:0] ctl, input logic ld, input logic [7:0] d,
                      input logic [7:0] code);
    if (ld) wb(1'b1, `TW_REG_DATA, d);
    wb(1'b1, `TW_REG_CTRL, ctl);
    wait_flag();
    wb(1'b0, `TW_REG_STATUS, 8'h00);
    chk_byte("status", code, q & 8'hF8);
    if (ld) chk_byte("slave byte", d, rx);
  endtask
  function automatic logic [7:0] addr_byte(input logic [6:0] a7, input logic rd);
    return {a7, rd};
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, ra[i], 8'h00);
      chk_byte("reset value", rv[i], q);
    end
    // Data write with the flag low, then the interrupt masked, raised, cleared
    wb(1'b1, `TW_REG_DATA, 8'h5A);
    wb(1'b0, `TW_REG_DATA, 8'h00);
    chk_byte("data", `TW_DATA_RST, q);
    wb(1'b0, `TW_REG_CTRL, 8'h00);
    chk_byte("wcol", 8'h01, {7'h00, q[`TW_CTRL_WCOL]});
    chk_byte("irq masked", 8'h00, {7'h00, irq});
    wb(1'b1, `TW_REG_IRQ_MASK, 8'h07);
    chk_byte("irq", 8'h01, {7'h00, irq});
    wb(1'b1, `TW_REG_IRQ_STAT, 8'h07);
    chk_byte("irq cleared", 8'h00, {7'h00, irq});
    wb(1'b1, `TW_REG_STATUS, 8'h03);
    wb(1'b0, `TW_REG_STATUS, 8'h00);
    chk_byte("prescaler", 8'hFB, q);
    // START, stretching, and a zero written to the flag
    step(8'hA4, 1'b0, 8'h00, `TW_SC_START);
    chk_byte("irq done", 8'h01, {7'h00, irq});
    repeat (40) @(posedge core_clk);
    chk_byte("scl held", 8'h00, {7'h00, scl});
    wb(1'b1, `TW_REG_CTRL, 8'h04);
    repeat (40) @(posedge core_clk);
    wb(1'b0, `TW_REG_CTRL, 8'h00);
    chk_byte("flag kept", 8'h01, {7'h00, q[`TW_CTRL_FLAG]});
    chk_byte("bytes", 8'h00, nbytes);
    // Address, then data with both extreme values and a random one
    step(8'h84, 1'b1, addr_byte(7'($random(seed)), 1'b0), `TW_SC_AW_ACK);
    for (int i = 0; i < 3; i++) begin
      step(8'h84, 1'b1, (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed)),
           `TW_SC_D_ACK);
    end
    // Repeated START, refused address, STOP followed by START
    step(8'hA4, 1'b0, 8'h00, `TW_SC_RSTART);
    nack <= 1'b1;
    step(8'h84, 1'b1, addr_byte(7'($random(seed)), 1'b0), `TW_SC_AW_NACK);
    nack <= 1'b0;
    step(8'hB4, 1'b0, 8'h00, `TW_SC_START);
    chk_byte("stops", 8'h01, nstops);
    step(8'h84, 1'b1, addr_byte(7'($random(seed)), 1'b0), `TW_SC_AW_ACK);
    step(8'hA4, 1'b0, 8'h00, `TW_SC_RSTART);
    step(8'h84, 1'b1, addr_byte(7'($random(seed)), 1'b1), `TW_SC_AR_ACK);
    // Receiver mode ignores a plain clear; seven bytes so far, none more
    wb(1'b1, `TW_REG_CTRL, 8'h84);
    repeat (40) @(posedge core_clk);
    chk_byte("bytes in receiver mode", 8'h07, nbytes);
    // STOP leaves the flag low and the bus idle
    wb(1'b1, `TW_REG_CTRL, 8'h94);
    repeat (60) @(posedge core_clk);
    wb(1'b0, `TW_REG_CTRL, 8'h00);
    chk_byte("ctrl after stop", 8'h04, q & 8'hF4);
    chk_byte("stops", 8'h02, nstops);
    wb(1'b0, `TW_REG_STATUS, 8'h00);
    chk_byte("status idle", `TW_SC_IDLE, q & 8'hF8);
    wb(1'b0, `TW_REG_IRQ_STAT, 8'h00);
    chk_byte("stop event", 8'h04, q & 8'h04);
    end_sim();
  end

  // Watchdog, far beyond the expected run of about 1250 cycles
  initial begin
    #400000;
    chk_byte("watchdog", 8'h00, 8'h01);
    end_sim();
  end
endmodule

bind two_wire_master_transmitter tw_master_properties #(.QUARTER(QUARTER)) u_props (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
  .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .irq_out(irq_out));
